/* File: inc/hlpt_pkg.sv */
package hlpt_pkg;
  // ==========================================================
  // widths
  localparam int CNT_W = 8;
  localparam int MODE_W = 5;
  localparam int POSTSCALE_MATCH_SELECT_W = 4;
  localparam int CKPS_W = 3;
  localparam int PRE_W = 7;
  // ==========================================================
  // reset values
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [3:0] POSTSCALE_MATCH_SELECT_RST = 4'h0;
  localparam logic [2:0] CKPS_RST = 3'h0;
  localparam logic [6:0] PRE_RST = 7'h00;
  localparam logic [3:0] POST_RST = 4'h0;
  // ==========================================================
  // mode groups, upper two bits of the mode field
  localparam logic [1:0] GRP_FREE = 2'h0;
  localparam logic [1:0] GRP_ONESHOT = 2'h1;
  localparam logic [1:0] GRP_MONO = 2'h2;
  // sub-modes of the free running group
  localparam logic [2:0] SUB_SOFT = 3'h0;
  localparam logic [2:0] SUB_GATE_HI = 3'h1;
  localparam logic [2:0] SUB_GATE_LO = 3'h2;
  localparam logic [2:0] SUB_RST_ANY = 3'h3;
  localparam logic [2:0] SUB_RST_RISE = 3'h4;
  localparam logic [2:0] SUB_RST_FALL = 3'h5;
  localparam logic [2:0] SUB_RST_LO = 3'h6;
  localparam logic [2:0] SUB_RST_HI = 3'h7;
  // sub-modes of the one-shot and monostable groups
  localparam logic [2:0] SUB_START_RISE = 3'h1;
  localparam logic [2:0] SUB_START_FALL = 3'h2;
  localparam logic [2:0] SUB_START_ANY = 3'h3;
  localparam logic [2:0] SUB_HL_RISE = 3'h4;
  localparam logic [2:0] SUB_HL_FALL = 3'h5;
  localparam logic [2:0] SUB_LVL_A = 3'h6;
  localparam logic [2:0] SUB_LVL_B = 3'h7;
  // ==========================================================
  // what the source of the external signal must keep, in timer ticks
  localparam int EDGE_SPACING_TICKS = 6;
  localparam int LEVEL_HOLD_TICKS = 3;
  // ==========================================================
  typedef enum logic [1:0] {HLPT_IDLE, HLPT_ARMED, HLPT_RUN} hlpt_phase_e;
endpackage : hlpt_pkg

/* File: hdl/hlpt_timer.sv */
`timescale 1ns/1ps
// Behaviour
// - postscaled period pulse lasts exactly one timer tick at postscale match
// - postscaler advances by one on each count equal to period limit
// - count and period-match timing signals always presented to PWM unit
// - reset-source select picks the external input; mode decides its effect
// - debug freeze makes levels and new edges ignored; an edge sampled just before it stays seen
// - mode 00/000 counts while enabled, halts when cleared, ignores signal
// - 001 counts while enabled and signal high; 010 while low
// - 011/100/101 run enabled, count reset on any, rising, falling edge
// - 110/111 held reset on low/high level, count at other level
// - one-shot 000 starts counting as soon as enable set
// - one-shot 001/010/011 wait for rising, falling, any edge to start
// - one-shot 100/101 first edge starts, later same edges reset count
// - one-shot 110 rise starts, low resets; 111 fall starts, high resets
// - monostable edge start, stops at 00h after match, enable kept
// - group 10 110/111 one-shot started by level, reset by other level
// - edge-start modes need a fresh edge after enable cycled
// - one-shot: tick after match clears enable, count stops at 00h
// - interrupt flag on postscale match; ratios 1:1 to 1:16
// - interrupt passes only with its enable bit set
// - count increments each prescaled tick, wraps to zero after match
// - device reset clears count and sets period limit to FFh
// - count write, control write, reset, external reset clear scalers
module hlpt_timer
  import hlpt_pkg::*;
#(
  parameter int SRC_COUNT = 32,
  parameter int SEL_W = $clog2(SRC_COUNT)
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic timerTickClock,
  input wire logic countWr,
  input wire logic [CNT_W-1:0] countWrData,
  input wire logic periodWr,
  input wire logic [CNT_W-1:0] periodWrData,
  input wire logic ctrlWr,
  input wire logic ctrlWrOn,
  input wire logic [POSTSCALE_MATCH_SELECT_W-1:0] ctrlWrPostscale,
  input wire logic [CKPS_W-1:0] ctrlWrPrescale,
  input wire logic [MODE_W-1:0] limitModeConfig,
  input wire logic [SEL_W-1:0] extResetSourceSelect,
  input wire logic [SRC_COUNT-1:0] extResetSources,
  input wire logic debugFreeze,
  input wire logic periodIrqEnable,
  input wire logic irqFlagClr,
  output logic [CNT_W-1:0] countValue,
  output logic [CNT_W-1:0] periodLimit,
  output logic timerOn,
  output logic [POSTSCALE_MATCH_SELECT_W-1:0] postscaleMatchSelect,
  output logic periodMatch,
  output logic timerTick,
  output logic periodEventPulse,
  output logic irqFlag,
  output logic irqReq
);
  // ==========================================================
  // state
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] period_r;
  logic on_r;
  logic [POSTSCALE_MATCH_SELECT_W-1:0] postscale_match_select_r;
  logic [CKPS_W-1:0] ckps_r;
  logic [PRE_W-1:0] preCnt_r;
  logic [POSTSCALE_MATCH_SELECT_W-1:0] postCnt_r;
  logic extNow_r;
  logic extPrev_r;
  hlpt_phase_e phase_r;
  logic match_r;
  logic tick_r;
  logic pulse_r;
  logic irqFlag_r;
  logic irqReq_r;

  logic [1:0] grp;
  logic [2:0] sub;
  logic [PRE_W-1:0] preTop;
  logic [7:0] preShift;
  logic tick;
  logic eRise;
  logic eFall;
  logic lvlHi;
  logic lvlLo;
  logic rstHi;
  logic rstLo;
  logic needEdge;
  logic startEdge;
  logic rstEv;
  logic gate;
  logic clrOn;
  logic rearm;
  logic resv;
  logic running;
  logic counting;
  logic hit;
  logic extRst;
  logic scalerClr;
  logic postHit;

  assign grp = limitModeConfig[4:3];
  assign sub = limitModeConfig[2:0];

  // ==========================================================
  // prescaler
  assign preShift = 8'h01 << ckps_r;
  assign preTop = PRE_W'(preShift - 8'h01);
  assign tick = timerTickClock && (preCnt_r == preTop);

  // ==========================================================
  // external signal; sampled on the timer clock so edges are seen once
  // edges are derived from held samples, so freezing the sampler hides new edges and holds one already sampled
  assign eRise = extNow_r & ~extPrev_r;
  assign eFall = ~extNow_r & extPrev_r;
  // under freeze the levels act as neither gate nor reset
  assign lvlHi = extNow_r | debugFreeze;
  assign lvlLo = ~extNow_r | debugFreeze;
  assign rstHi = extNow_r & ~debugFreeze;
  assign rstLo = ~extNow_r & ~debugFreeze;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      extNow_r <= 1'b0;
      extPrev_r <= 1'b0;
    end else if (timerTickClock && !debugFreeze) begin
      extNow_r <= extResetSources[extResetSourceSelect];
      extPrev_r <= extNow_r;
    end
  end

  // ==========================================================
  // mode decode
  always_comb begin
    needEdge = 1'b0;
    startEdge = 1'b0;
    rstEv = 1'b0;
    gate = 1'b1;
    clrOn = 1'b0;
    rearm = 1'b0;
    resv = 1'b0;
    case (grp)
      GRP_FREE: begin
        case (sub)
          SUB_GATE_HI: gate = lvlHi;
          SUB_GATE_LO: gate = lvlLo;
          SUB_RST_ANY: rstEv = eRise | eFall;
          SUB_RST_RISE: rstEv = eRise;
          SUB_RST_FALL: rstEv = eFall;
          SUB_RST_LO: rstEv = rstLo;
          SUB_RST_HI: rstEv = rstHi;
          default: gate = 1'b1;
        endcase
      end
      GRP_ONESHOT: begin
        clrOn = 1'b1;
        case (sub)
          SUB_START_RISE: begin
            needEdge = 1'b1;
            startEdge = eRise;
          end
          SUB_START_FALL: begin
            needEdge = 1'b1;
            startEdge = eFall;
          end
          SUB_START_ANY: begin
            needEdge = 1'b1;
            startEdge = eRise | eFall;
          end
          SUB_HL_RISE: begin
            needEdge = 1'b1;
            startEdge = eRise;
            rstEv = eRise;
          end
          SUB_HL_FALL: begin
            needEdge = 1'b1;
            startEdge = eFall;
            rstEv = eFall;
          end
          SUB_LVL_A: begin
            needEdge = 1'b1;
            startEdge = eRise;
            rstEv = rstLo;
          end
          SUB_LVL_B: begin
            needEdge = 1'b1;
            startEdge = eFall;
            rstEv = rstHi;
          end
          default: needEdge = 1'b0;
        endcase
      end
      GRP_MONO: begin
        case (sub)
          SUB_START_RISE: begin
            needEdge = 1'b1;
            startEdge = eRise;
            rearm = 1'b1;
          end
          SUB_START_FALL: begin
            needEdge = 1'b1;
            startEdge = eFall;
            rearm = 1'b1;
          end
          SUB_START_ANY: begin
            needEdge = 1'b1;
            startEdge = eRise | eFall;
            rearm = 1'b1;
          end
          SUB_LVL_A: begin
            clrOn = 1'b1;
            gate = lvlHi;
            rstEv = rstLo;
          end
          SUB_LVL_B: begin
            clrOn = 1'b1;
            gate = lvlLo;
            rstEv = rstHi;
          end
          default: resv = 1'b1;
        endcase
      end
      default: resv = 1'b1;
    endcase
  end

  assign running = (phase_r == HLPT_RUN) && on_r;
  assign extRst = tick && running && rstEv;
  assign counting = tick && running && gate && !rstEv && !resv;
  assign hit = counting && (count_r == period_r);
  assign postHit = hit && (postCnt_r == postscale_match_select_r);
  assign scalerClr = countWr || ctrlWr || extRst;

  // ==========================================================
  // run phase: idle while off, armed while waiting for an edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= HLPT_IDLE;
    end else if (!on_r || resv) begin
      phase_r <= HLPT_IDLE;
    end else begin
      case (phase_r)
        HLPT_IDLE: phase_r <= needEdge ? HLPT_ARMED : HLPT_RUN;
        HLPT_ARMED: begin
          if (tick && startEdge) begin
            phase_r <= HLPT_RUN;
          end
        end
        HLPT_RUN: begin
          if (hit && rearm) begin
            phase_r <= HLPT_ARMED;
          end else if (extRst && needEdge && (sub == SUB_LVL_A || sub == SUB_LVL_B)) begin
            phase_r <= HLPT_ARMED;
          end
        end
        default: phase_r <= HLPT_IDLE;
      endcase
    end
  end

  // ==========================================================
  // control word; a software write wins over the hardware clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_r <= 1'b0;
      postscale_match_select_r <= POSTSCALE_MATCH_SELECT_RST;
      ckps_r <= CKPS_RST;
    end else if (ctrlWr) begin
      on_r <= ctrlWrOn;
      postscale_match_select_r <= ctrlWrPostscale;
      ckps_r <= ctrlWrPrescale;
    end else if (hit && clrOn) begin
      on_r <= 1'b0;
    end
  end

  // ==========================================================
  // count and period
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= COUNT_RST;
    end else if (countWr) begin
      count_r <= countWrData;
    end else if (resv) begin
      count_r <= COUNT_RST;
    end else if (extRst || hit) begin
      count_r <= COUNT_RST;
    end else if (counting) begin
      count_r <= count_r + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_r <= PERIOD_RST;
    end else if (periodWr) begin
      period_r <= periodWrData;
    end
  end

  // ==========================================================
  // prescaler and postscaler
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_r <= PRE_RST;
    end else if (scalerClr) begin
      preCnt_r <= PRE_RST;
    end else if (timerTickClock) begin
      preCnt_r <= tick ? PRE_RST : preCnt_r + 7'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      postCnt_r <= POST_RST;
    end else if (scalerClr) begin
      postCnt_r <= POST_RST;
    end else if (postHit) begin
      postCnt_r <= POST_RST;
    end else if (hit) begin
      postCnt_r <= postCnt_r + 4'h1;
    end
  end

  // ==========================================================
  // outputs; the pulse is held from one tick to the next
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_r <= 1'b0;
    end else if (tick) begin
      pulse_r <= postHit;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      match_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      match_r <= (count_r == period_r);
      tick_r <= tick;
    end
  end

  // flag set wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqFlag_r <= 1'b0;
      irqReq_r <= 1'b0;
    end else begin
      irqFlag_r <= postHit | (irqFlag_r & ~irqFlagClr);
      irqReq_r <= (postHit | (irqFlag_r & ~irqFlagClr)) & periodIrqEnable;
    end
  end

  assign countValue = count_r;
  assign periodLimit = period_r;
  assign timerOn = on_r;
  assign postscaleMatchSelect = postscale_match_select_r;
  assign periodMatch = match_r;
  assign timerTick = tick_r;
  assign periodEventPulse = pulse_r;
  assign irqFlag = irqFlag_r;
  assign irqReq = irqReq_r;
endmodule : hlpt_timer

/* File: dv/hlpt_timer_assertions.sv */
`timescale 1ns/1ps
// ==========================================================
// checker on the timer ports
module hlpt_timer_assertions
  import hlpt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic timerTickClock,
  input wire logic countWr,
  input wire logic [CNT_W-1:0] countWrData,
  input wire logic periodWr,
  input wire logic [CNT_W-1:0] periodWrData,
  input wire logic ctrlWr,
  input wire logic ctrlWrOn,
  input wire logic [POSTSCALE_MATCH_SELECT_W-1:0] ctrlWrPostscale,
  input wire logic [MODE_W-1:0] limitModeConfig,
  input wire logic periodIrqEnable,
  input wire logic [CNT_W-1:0] countValue,
  input wire logic [CNT_W-1:0] periodLimit,
  input wire logic timerOn,
  input wire logic [POSTSCALE_MATCH_SELECT_W-1:0] postscaleMatchSelect,
  input wire logic periodEventPulse,
  input wire logic irqFlag,
  input wire logic irqReq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // a write followed by a quiet cycle must leave the written count in place
  // reserved modes clear the count on their own, so they are left out
  sequence s_wr_quiet;
    countWr && !timerTickClock ##1 !countWr && !timerTickClock && limitModeConfig[4:3] != 2'h3
      && limitModeConfig != 5'h10 && limitModeConfig != 5'h14 && limitModeConfig != 5'h15;
  endsequence
  AST_COUNT_WR: assert property (s_wr_quiet |=> countValue == $past(countWrData, 2))
    else $error("count write lost");
  AST_PERIOD_WR: assert property (periodWr |=> periodLimit == $past(periodWrData))
    else $error("period write lost");
  AST_ON_WR: assert property (ctrlWr |=> timerOn == $past(ctrlWrOn))
    else $error("enable write lost");
  AST_POST_SEL: assert property (ctrlWr |=> postscaleMatchSelect == $past(ctrlWrPostscale))
    else $error("postscale select lost");
  AST_CTRL_KEEP: assert property (ctrlWr && !countWr && !timerTickClock |=> $stable(countValue))
    else $error("control write moved count");
  AST_HALT: assert property (limitModeConfig == 5'h00 && !timerOn && !countWr && !ctrlWr |=> $stable(countValue))
    else $error("count moved while halted");
  AST_STEP: assert property (!$past(countWr) && countValue != 8'h00 && countValue != $past(countValue)
    |-> countValue == $past(countValue) + 8'h01)
    else $error("count jumped");
  AST_RESERVED: assert property (limitModeConfig[4:3] == 2'h3 && !countWr |=> countValue == 8'h00)
    else $error("reserved mode counted");
  AST_IRQ_GATE: assert property (irqReq |-> $past(periodIrqEnable) && irqFlag)
    else $error("request without enable");
  AST_PULSE_FLAG: assert property ($rose(periodEventPulse) |-> irqFlag)
    else $error("pulse without flag");
endmodule : hlpt_timer_assertions

bind hlpt_timer hlpt_timer_assertions chk (.ref_clk, .rst_n, .timerTickClock, .countWr, .countWrData, .periodWr,
  .periodWrData, .ctrlWr, .ctrlWrOn, .ctrlWrPostscale, .limitModeConfig, .periodIrqEnable, .countValue,
  .periodLimit, .timerOn, .postscaleMatchSelect, .periodEventPulse, .irqFlag, .irqReq);

/* File: dv/hlpt_ext_src.sv */
`timescale 1ns/1ps
// ==========================================================
// external reset signal source
module hlpt_ext_src
  import hlpt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic tick,
  input wire logic [4:0] sel,
  output logic [31:0] srcs
);
  logic level;
  logic want;
  logic [3:0] gap;
  logic [31:0] noise;
  initial begin
    level = 1'b0;
    want = 1'b0;
    gap = 4'hf;
    noise = 32'h00000000;
  end
  // unselected lines toggle so a wrong select cannot pass unseen
  always @(negedge ref_clk) begin
    noise <= ~noise;
    if (want != level && gap >= EDGE_SPACING_TICKS) begin
      level <= want;
      gap <= 4'h0;
    end else if (tick && gap != 4'hf) begin
      gap <= gap + 4'h1;
    end
  end
  assign srcs = (noise & ~(32'h00000001 << sel)) | ({31'h0, level} << sel);
endmodule : hlpt_ext_src

/* File: dv/hlpt_timer_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// bench
module hlpt_timer_tb;
  import hlpt_pkg::*;
  logic ref_clk, rst_n, timerTickClock, countWr, periodWr, ctrlWr, ctrlWrOn;
  logic debugFreeze, periodIrqEnable, irqFlagClr;
  logic [7:0] countWrData, periodWrData, countValue, periodLimit, cnt, per, v;
  logic [3:0] ctrlWrPostscale, postscaleMatchSelect;
  logic [2:0] ctrlWrPrescale;
  logic [4:0] limitModeConfig, extSel;
  logic [31:0] extSrcs, rnd;
  logic timerOn, periodMatch, timerTick, periodEventPulse, irqFlag, irqReq;
  logic [10:0] e;
  logic [10:0] expQ[$];
  int n_errors, checks;
  event seen;
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  hlpt_timer dut (.ref_clk, .rst_n, .timerTickClock, .countWr, .countWrData, .periodWr, .periodWrData, .ctrlWr,
    .ctrlWrOn, .ctrlWrPostscale, .ctrlWrPrescale, .limitModeConfig, .extResetSourceSelect(extSel),
    .extResetSources(extSrcs), .debugFreeze, .periodIrqEnable, .irqFlagClr, .countValue, .periodLimit, .timerOn,
    .postscaleMatchSelect, .periodMatch, .timerTick, .periodEventPulse, .irqFlag, .irqReq);
  hlpt_ext_src src (.ref_clk, .tick(timerTickClock), .sel(extSel), .srcs(extSrcs));
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    checks++;
    if (got !== want) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, got, want);
    end
  endtask : check
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic note(input logic [2:0] s, input logic [7:0] x);
    expQ.push_back({s, x});
    ->seen;
  endtask : note
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  // bare ticks with nothing noted, for settling the external line
  task automatic tk(input int n);
    repeat (n) begin
      timerTickClock <= 1'b1;
      cyc(1);
      timerTickClock <= 1'b0;
      cyc(1);
    end
  endtask : tk
  // one prescaled tick per call, prescaler at 1:1
  task automatic step(input logic adv);
    timerTickClock <= 1'b1;
    cyc(1);
    timerTickClock <= 1'b0;
    note(3'h7, 8'h01);
    cyc(1);
    if (adv) cnt = (cnt == per) ? 8'h00 : cnt + 8'h01;
    note(3'h0, cnt);
    note(3'h6, {7'h00, cnt == per});
  endtask : step
  task automatic wr_reg(input logic isPer, input logic [7:0] d);
    periodWr <= isPer;
    countWr <= !isPer;
    countWrData <= d;
    periodWrData <= d;
    cyc(1);
    periodWr <= 1'b0;
    countWr <= 1'b0;
    cyc(1);
  endtask : wr_reg
  task automatic wr_ctrl(input logic on, input logic [3:0] ps);
    ctrlWrOn <= on;
    ctrlWrPostscale <= ps;
    ctrlWr <= 1'b1;
    cyc(1);
    ctrlWr <= 1'b0;
    cyc(2);
  endtask : wr_ctrl
  // ==========================================================
  // monitor: every noted result is compared oldest first
  initial forever begin
    @(seen);
    while (expQ.size() > 0) begin
      e = expQ.pop_front();
      case (e[10:8])
        3'h0: v = countValue;
        3'h1: v = periodLimit;
        3'h2: v = {7'h00, timerOn};
        3'h3: v = {7'h00, irqFlag};
        3'h4: v = {7'h00, irqReq};
        3'h5: v = {7'h00, periodEventPulse};
        3'h6: v = {7'h00, periodMatch};
        default: v = {7'h00, timerTick};
      endcase
      check(v, e[7:0]);
    end
  end
  initial begin
    cyc(20000);
    n_errors++;
    report_and_stop();
  end
  // ==========================================================
  // main sequence
  initial begin
    {rst_n, timerTickClock, countWr, periodWr, ctrlWr, ctrlWrOn, debugFreeze, periodIrqEnable, irqFlagClr} = 9'h000;
    {countWrData, periodWrData, ctrlWrPostscale, ctrlWrPrescale, limitModeConfig} = 28'h0000000;
    rnd = 32'h0000000a;
    rnd = xs(rnd);
    extSel = rnd[4:0];
    cyc(10);
    rst_n <= 1'b1;
    cyc(1);
    note(3'h1, 8'hff);
    note(3'h0, 8'h00);
    rnd = xs(rnd);
    per = {5'h00, rnd[2:0]} | 8'h04;
    wr_reg(1'b1, per);
    note(3'h1, per);
    cnt = rnd[15:8] & 8'h03;
    wr_reg(1'b0, cnt);
    note(3'h0, cnt);
    wr_ctrl(1'b1, 4'h0);
    repeat (10) step(1'b1);
    wr_ctrl(1'b0, 4'h0);
    step(1'b0);
    // gates: wait out the edge spacing, then step one tick, counted only at the open level; freeze opens the gate
    for (int m = 1; m <= 2; m++) begin
      limitModeConfig <= m[4:0];
      wr_ctrl(1'b1, 4'h0);
      for (int lv = 0; lv < 2; lv++) begin
        src.want <= lv[0];
        tk(7);
        note(3'h2, 8'h01);
        wr_reg(1'b0, 8'h00);
        cnt = 8'h00;
        step((m == 1) ? lv[0] : !lv[0]);
        debugFreeze <= 1'b1;
        step(1'b1);
        debugFreeze <= 1'b0;
      end
    end
    limitModeConfig <= 5'h08;
    wr_reg(1'b0, 8'h00);
    cnt = 8'h00;
    wr_ctrl(1'b1, 4'h0);
    repeat (int'(per) + 1) step(1'b1);
    note(3'h2, 8'h00);
    step(1'b0);
    for (int r = 0; r < 5; r++) begin
      limitModeConfig <= (r == 0) ? 5'h10 : (r == 1) ? 5'h14 : (r == 2) ? 5'h15 : (r == 3) ? 5'h18 : 5'h1f;
      wr_ctrl(1'b1, 4'h0);
      wr_reg(1'b0, 8'h05);
      cnt = 8'h00;
      step(1'b0);
    end
    limitModeConfig <= 5'h00;
    per = 8'h01;
    wr_reg(1'b1, per);
    wr_reg(1'b0, 8'h00);
    cnt = 8'h00;
    periodIrqEnable <= 1'b1;
    note(3'h3, 8'h01);
    irqFlagClr <= 1'b1;
    wr_ctrl(1'b1, 4'h1);
    irqFlagClr <= 1'b0;
    note(3'h3, 8'h00);
    repeat (2) step(1'b1);
    note(3'h3, 8'h00);
    repeat (2) step(1'b1);
    note(3'h3, 8'h01);
    note(3'h5, 8'h01);
    note(3'h4, 8'h01);
    periodIrqEnable <= 1'b0;
    irqFlagClr <= 1'b1;
    cyc(1);
    irqFlagClr <= 1'b0;
    step(1'b1);
    note(3'h5, 8'h00);
    repeat (3) step(1'b1);
    note(3'h4, 8'h00);
    note(3'h3, 8'h01);
    // ==========================================================
    // monostable rising start: stops at zero after the match, enable kept
    limitModeConfig <= 5'h11;
    wr_ctrl(1'b0, 4'h0);
    src.want <= 1'b0;
    tk(7);
    wr_reg(1'b0, 8'h00);
    cnt = 8'h00;
    wr_ctrl(1'b1, 4'h0);
    step(1'b0);
    src.want <= 1'b1;
    tk(3);
    step(1'b1);
    step(1'b1);
    note(3'h2, 8'h01);
    step(1'b0);
    rst_n <= 1'b0;
    cyc(2);
    note(3'h0, 8'h00);
    note(3'h1, 8'hff);
    rst_n <= 1'b1;
    cyc(2);
    report_and_stop();
  end
endmodule : hlpt_timer_tb
